/* spcr_regs.sv */
// serial port configuration registers with readback source selection
//
// What this block does
// - split bit clear: reads and writes use bidirectional line, output line off.
// - split bit set: reads leave on output line, writes on bidirectional line; ignored in I2C mode.
// - order bit set: shift least significant bit first, addresses count up; ignored in I2C mode.
// - order bit clear: MSB first, addresses count down; also forced in I2C mode.
// - writing soft reset bit restores all defaults, then the bit clears itself.
// - readback bit clear: buffered registers read back their active values.
// - readback bit set: buffered registers read back their pending values.
// - two bytes hold a 16-bit user tag, default zero, no other effect.
`timescale 1ns/100ps
module spcr_regs (
    input  wire logic                       mclk_i,
    input  wire logic                       reset_n_i,
    input  wire logic                       i2c_mode_i,
    input  wire logic [spcr_pkg::ADDR_W-1:0] reg_addr_i,
    input  wire logic                       reg_wr_i,
    input  wire logic [spcr_pkg::DATA_W-1:0] reg_wdata_i,
    input  wire logic                       reg_rd_i,
    input  wire logic [spcr_pkg::DATA_W-1:0] active_rdata_i,
    input  wire logic [spcr_pkg::DATA_W-1:0] buffer_rdata_i,
    output logic      [spcr_pkg::DATA_W-1:0] reg_rdata_o,
    output logic                            reg_rvalid_o,
    output logic                            read_on_bidir_o,
    output logic                            read_on_split_o,
    output logic                            lsb_first_o,
    output logic                            addr_incr_o,
    output logic                            soft_reset_o,
    output logic                            readback_buffered_o,
    output logic      [spcr_pkg::TAG_W-1:0]  config_image_tag_o
);
    import spcr_pkg::*;

    // setup register fields
    logic              split_line_select_ff;
    logic              lsb_first_ff;

    // readback source and user tag
    logic              rb_buffered_ff;
    logic [7:0]        tag_low_ff;
    logic [7:0]        tag_high_ff;

    // pulse towards the rest of the device
    logic              soft_reset_ff;

    // read return path
    logic [7:0]        rdata_ff;
    logic              rvalid_ff;
    logic [7:0]        nxt_rdata;

    // registered pin steering
    logic              read_on_bidir_ff;
    logic              read_on_split_ff;
    logic              lsb_pin_ff;
    logic              addr_incr_ff;

    // write decodes
    logic              wr_setup;
    logic              wr_readback;
    logic              wr_tag_low;
    logic              wr_tag_high;
    logic              do_soft_reset;
    logic              bank_reset;

    // effective mode after the i2c override
    logic              split_eff;
    logic              lsb_eff;
    logic [7:0]        setup_read;

    assign wr_setup    = reg_wr_i && (reg_addr_i == ADDR_PORT_SETUP);
    assign wr_readback = reg_wr_i && (reg_addr_i == ADDR_READBACK);
    assign wr_tag_low  = reg_wr_i && (reg_addr_i == ADDR_TAG_LOW);
    assign wr_tag_high = reg_wr_i && (reg_addr_i == ADDR_TAG_HIGH);

    // only the high nibble is decoded; the mirror makes it order proof
    assign do_soft_reset = wr_setup && reg_wdata_i[BIT_SOFT_RESET];

    // soft reset clears this bank too, so the pulse has to be registered
    assign bank_reset = !reset_n_i || do_soft_reset;

    // i2c mode keeps the stored bits but forces the safe pin behaviour
    assign split_eff = split_line_select_ff && !i2c_mode_i;
    assign lsb_eff   = lsb_first_ff && !i2c_mode_i;

    // soft reset bit is never stored, so it reads back as zero
    assign setup_read = {split_line_select_ff,
                         lsb_first_ff,
                         1'b0,
                         1'b0,
                         1'b0,
                         1'b0,
                         lsb_first_ff,
                         split_line_select_ff};

    always_ff @(posedge mclk_i) begin
        if (bank_reset) begin
            split_line_select_ff <= RST_SPLIT_LINE;
        end else if (wr_setup) begin
            split_line_select_ff <= reg_wdata_i[BIT_SPLIT_LINE];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (bank_reset) begin
            lsb_first_ff <= RST_LSB_FIRST;
        end else if (wr_setup) begin
            lsb_first_ff <= reg_wdata_i[BIT_LSB_FIRST];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (bank_reset) begin
            rb_buffered_ff <= RST_RB_BUFFERED;
        end else if (wr_readback) begin
            rb_buffered_ff <= reg_wdata_i[BIT_RB_BUFFERED];
        end
    end

    // tag bytes are independent; no latching between the halves
    always_ff @(posedge mclk_i) begin
        if (bank_reset) begin
            tag_low_ff <= RST_TAG_BYTE;
        end else if (wr_tag_low) begin
            tag_low_ff <= reg_wdata_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (bank_reset) begin
            tag_high_ff <= RST_TAG_BYTE;
        end else if (wr_tag_high) begin
            tag_high_ff <= reg_wdata_i;
        end
    end

    // one-cycle pulse tells the rest of the device to reload its defaults
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            soft_reset_ff <= RST_SOFT_PULSE;
        end else begin
            soft_reset_ff <= do_soft_reset;
        end
    end

    // outside registers answer in the same cycle, so no wait states
    always_comb begin
        if (reg_addr_i == ADDR_PORT_SETUP) begin
            nxt_rdata = setup_read;
        end else if (reg_addr_i == ADDR_READBACK) begin
            nxt_rdata = {7'h00, rb_buffered_ff};
        end else if (reg_addr_i == ADDR_TAG_LOW) begin
            nxt_rdata = tag_low_ff;
        end else if (reg_addr_i == ADDR_TAG_HIGH) begin
            nxt_rdata = tag_high_ff;
        end else if (rb_buffered_ff) begin
            nxt_rdata = buffer_rdata_i;
        end else begin
            nxt_rdata = active_rdata_i;
        end
    end

    // read data holds until the next read
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            rdata_ff <= RST_RDATA;
        end else if (reg_rd_i) begin
            rdata_ff <= nxt_rdata;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            rvalid_ff <= RST_RVALID;
        end else begin
            rvalid_ff <= reg_rd_i;
        end
    end

    // pin steering registered so the output enables never glitch
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            read_on_bidir_ff <= RST_READ_BIDIR;
        end else begin
            read_on_bidir_ff <= !split_eff;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            read_on_split_ff <= RST_READ_SPLIT;
        end else begin
            read_on_split_ff <= split_eff;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            lsb_pin_ff <= RST_LSB_PIN;
        end else begin
            lsb_pin_ff <= lsb_eff;
        end
    end

    // the address direction follows the bit order by definition
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            addr_incr_ff <= RST_ADDR_INCR;
        end else begin
            addr_incr_ff <= lsb_eff;
        end
    end

    assign read_on_bidir_o     = read_on_bidir_ff;
    assign read_on_split_o     = read_on_split_ff;
    assign lsb_first_o         = lsb_pin_ff;
    assign addr_incr_o         = addr_incr_ff;
    assign reg_rdata_o         = rdata_ff;
    assign reg_rvalid_o        = rvalid_ff;
    assign soft_reset_o        = soft_reset_ff;
    assign readback_buffered_o = rb_buffered_ff;
    assign config_image_tag_o  = {tag_high_ff, tag_low_ff};
endmodule : spcr_regs

/* spcr_pkg.sv */
// constants for the serial port configuration register bank
package spcr_pkg;
    localparam int          ADDR_W           = 12;
    localparam int          DATA_W           = 8;
    localparam int          TAG_W            = 16;
    localparam logic [11:0] ADDR_PORT_SETUP  = 12'h000;
    localparam logic [11:0] ADDR_READBACK    = 12'h004;
    localparam logic [11:0] ADDR_TAG_LOW     = 12'h005;
    localparam logic [11:0] ADDR_TAG_HIGH    = 12'h006;
    localparam int          BIT_SPLIT_LINE   = 7;
    localparam int          BIT_LSB_FIRST    = 6;
    localparam int          BIT_SOFT_RESET   = 5;
    localparam int          BIT_RB_BUFFERED  = 0;
    localparam logic        RST_SPLIT_LINE   = 1'b0;
    localparam logic        RST_LSB_FIRST    = 1'b0;
    localparam logic        RST_RB_BUFFERED  = 1'b0;
    localparam logic [7:0]  RST_TAG_BYTE     = 8'h00;
    localparam logic [7:0]  RST_RDATA        = 8'h00;
    localparam logic        RST_RVALID       = 1'b0;
    localparam logic        RST_SOFT_PULSE   = 1'b0;
    localparam logic        RST_READ_BIDIR   = 1'b1;
    localparam logic        RST_READ_SPLIT   = 1'b0;
    localparam logic        RST_LSB_PIN      = 1'b0;
    localparam logic        RST_ADDR_INCR    = 1'b0;
endpackage : spcr_pkg

/* spcr_regs_monitor.sv */
// assertion checker for the serial port configuration registers
`timescale 1ns/100ps
module spcr_regs_monitor (
    input wire logic        mclk_i,
    input wire logic        reset_n_i,
    input wire logic        i2c_mode_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic [7:0]  active_rdata_i,
    input wire logic [7:0]  buffer_rdata_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic        reg_rvalid_o,
    input wire logic        read_on_bidir_o,
    input wire logic        read_on_split_o,
    input wire logic        lsb_first_o,
    input wire logic        addr_incr_o,
    input wire logic        soft_reset_o,
    input wire logic        readback_buffered_o,
    input wire logic [15:0] config_image_tag_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    // reads outside the bank come from the outside register source
    wire logic w0 = reg_wr_i && reg_addr_i == 12'h000;
    wire logic rx = reg_rd_i && reg_addr_i > 12'h006;
    property p_act;
        rx && !readback_buffered_o |=> reg_rdata_o == $past(active_rdata_i);
    endproperty
    a_act: assert property (p_act) else $error("active read");
    property p_buf;
        rx && readback_buffered_o |=> reg_rdata_o == $past(buffer_rdata_i);
    endproperty
    a_buf: assert property (p_buf) else $error("buffer read");
    property p_line;
        read_on_bidir_o != read_on_split_o;
    endproperty
    a_line: assert property (p_line) else $error("line steering");
    property p_split;
        w0 && reg_wdata_i[7:5] == 3'b100 && !i2c_mode_i ##1
            !i2c_mode_i [*2] |-> read_on_split_o;
    endproperty
    a_split: assert property (p_split) else $error("split line");
    property p_ord;
        lsb_first_o == addr_incr_o;
    endproperty
    a_ord: assert property (p_ord) else $error("order");
    property p_i2c;
        i2c_mode_i [*3] |-> !read_on_split_o && !lsb_first_o;
    endproperty
    a_i2c: assert property (p_i2c) else $error("i2c override");
    property p_srst;
        w0 && reg_wdata_i[5] |=> soft_reset_o &&
            config_image_tag_o == 16'h0000 && !readback_buffered_o;
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset");
    property p_tag;
        reg_wr_i && reg_addr_i == 12'h005 |=>
            config_image_tag_o[7:0] == $past(reg_wdata_i);
    endproperty
    a_tag: assert property (p_tag) else $error("tag low");
    property p_rvalid;
        reg_rd_i |=> reg_rvalid_o;
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("read valid");
    property p_rvidle;
        !reg_rd_i |=> !reg_rvalid_o;
    endproperty
    a_rvidle: assert property (p_rvidle) else $error("read idle");
endmodule : spcr_regs_monitor

/* spcr_host.sv */
// host controller model driving the register port
`timescale 1ns/100ps
module spcr_host (
    input  wire logic        mclk_i,
    input  wire logic [7:0]  rdata_i,
    output logic      [11:0] addr_o = 12'hFFF,
    output logic      [7:0]  wdata_o = 8'h00,
    output logic             wr_o = 1'b0,
    output logic             rd_o = 1'b0
);
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        addr_o = a;
        wr_o = 1'b1;
        wdata_o = a == 12'h000 ? {d[7:4], d[4], d[5], d[6], d[7]} : d;
        @(negedge mclk_i);
        wr_o = 1'b0;
        wdata_o = ~wdata_o;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(negedge mclk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge mclk_i);
        rd_o = 1'b0;
        d = rdata_i;
    endtask : rd
endmodule : spcr_host

/* spcr_regs_bench.sv */
// self-checking bench for the serial port configuration registers
`timescale 1ns/100ps
module spcr_regs_bench;
    logic mclk_i = 1'b0, reset_n_i = 1'b0, i2c_mode_i = 1'b0;
    logic [11:0] a;
    logic [7:0] wd, rdata, d;
    logic wr, rd, sp, bi, lsb, inc, srst, rbb;
    logic [15:0] tag;
    int fails = 0, samples_checked = 0;
    always #4 mclk_i = ~mclk_i;
    spcr_host i_spcr_host (.mclk_i, .rdata_i(rdata), .addr_o(a),
        .wdata_o(wd), .wr_o(wr), .rd_o(rd));
    spcr_regs i_spcr_regs (.mclk_i, .reset_n_i, .i2c_mode_i, .reg_addr_i(a),
        .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .active_rdata_i(a[7:0] ^ 8'h5A), .buffer_rdata_i(a[7:0] ^ 8'hA5),
        .reg_rvalid_o(), .read_on_bidir_o(bi), .read_on_split_o(sp),
        .lsb_first_o(lsb), .addr_incr_o(inc), .soft_reset_o(srst),
        .readback_buffered_o(rbb), .config_image_tag_o(tag));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("Error %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic results;
        $display("checked %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    task automatic t_setup;
        i_spcr_host.rd(12'h000, d);
        chk({d, bi, sp}, 10'h002);
        i_spcr_host.wr(12'h000, 8'hC0);
        i_spcr_host.rd(12'h000, d);
        chk({d, sp, bi, lsb, inc}, 12'hC3B);
        i_spcr_host.wr(12'h000, 8'h00);
        @(negedge mclk_i) i2c_mode_i = 1'b1;
        i_spcr_host.wr(12'h000, 8'hC0);
        i_spcr_host.rd(12'h000, d);
        chk({d, sp, bi, lsb, inc}, 12'hC34);
        @(negedge mclk_i) i2c_mode_i = 1'b0;
        i_spcr_host.rd(12'h000, d);
        chk({sp, lsb}, 2'b11);
        $display("t_setup done");
    endtask : t_setup
    task automatic t_rb;
        i_spcr_host.rd(12'h010, d);
        chk(d, 8'h4A);
        i_spcr_host.wr(12'h004, 8'h01);
        i_spcr_host.rd(12'h010, d);
        chk({d, rbb}, 9'h16B);
        $display("t_rb done");
    endtask : t_rb
    task automatic t_tag;
        i_spcr_host.wr(12'h005, 8'h3C);
        i_spcr_host.wr(12'h006, 8'hA5);
        chk(tag, 16'hA53C);
        i_spcr_host.wr(12'h000, 8'h20);
        chk(srst, 1'b1);
        i_spcr_host.rd(12'h000, d);
        chk({tag, d, sp, lsb, rbb, srst}, 28'h0);
        $display("t_tag done");
    endtask : t_tag
    initial begin
        #20000;
        fails++;
        results;
    end
    initial begin
        repeat (16) @(negedge mclk_i);
        reset_n_i = 1'b1;
        t_setup;
        t_rb;
        t_tag;
        results;
    end
endmodule : spcr_regs_bench
bind spcr_regs spcr_regs_monitor i_spcr_regs_monitor (.*);
